// file: common/gmf_pkg.sv
// package: offsets, reset values, field positions and types of the block
`default_nettype none

package gmf_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register offsets on the control port
  localparam logic [7:0] MAILBOX_OFFSET = 8'h19;
  localparam logic [7:0] CONFIG_OFFSET = 8'h1a;
  localparam logic [7:0] TALLY_OFFSET = 8'h1b;

  // values after reset, and the tally ceiling
  localparam logic [7:0] MAILBOX_RESET = 8'h01;
  localparam logic [7:0] CONFIG_RESET = 8'h00;
  localparam logic [7:0] TALLY_RESET = 8'h00;
  localparam logic [7:0] READ_IDLE_VALUE = 8'h00;
  localparam logic [7:0] TALLY_MAX = 8'hff;

  ////////////////////////////////////////////////////////////////////////////
  // field positions inside pin_nine_and_global_pad_config
  localparam int unsigned GLOB_LEVEL_BIT = 7;
  localparam int unsigned GLOB_FORCE_DIR_BIT = 5;
  localparam int unsigned GLOB_FORCE_EN_BIT = 4;
  localparam int unsigned PIN_NINE_LEVEL_BIT = 3;
  localparam int unsigned PIN_NINE_DIR_BIT = 1;
  localparam int unsigned PIN_NINE_EN_BIT = 0;

  ////////////////////////////////////////////////////////////////////////////
  // timing: oscillator period sets the unit of the measurement window
  localparam int unsigned OSC_PERIOD_NS = 40;
  localparam int unsigned REF_CLK_PERIOD_NS = 40;
  localparam int unsigned OSC_CYCLES_RAW =
    (OSC_PERIOD_NS + REF_CLK_PERIOD_NS - 1) / REF_CLK_PERIOD_NS;
  localparam int unsigned OSC_CYCLES = (OSC_CYCLES_RAW < 1) ? 1 :
    OSC_CYCLES_RAW;

  ////////////////////////////////////////////////////////////////////////////
  // types
  typedef struct packed {
    logic drive_level;
    logic direction;
    logic function_enable;
  } gmf_pin_cfg_s;

  typedef struct packed {
    logic wr_en;
    logic rd_en;
    logic [7:0] addr;
    logic [7:0] wdata;
  } gmf_reg_req_s;

  // encoding is {direction, enable}
  typedef enum logic [1:0] {
    GMF_PAD_FUNC = 2'b00,
    GMF_PAD_GPIO_OUT = 2'b01,
    GMF_PAD_TRI = 2'b10,
    GMF_PAD_GPIO_IN = 2'b11
  } gmf_pad_mode_e;

  typedef enum logic {
    GMF_TALLY_IDLE = 1'b0,
    GMF_TALLY_COUNT = 1'b1
  } gmf_tally_state_e;

endpackage : gmf_pkg

`default_nettype wire

// file: logic/gmf_edge_sync.sv
// module: synchroniser and rising edge detector for a foreign clock input
`default_nettype none

module gmf_edge_sync (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic async_in,
  output logic rise_pulse
);

  logic meta_reg;
  logic sync_reg;
  logic last_reg;

  ////////////////////////////////////////////////////////////////////////////
  // two-flop synchroniser; meta_reg is read by sync_reg alone
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
    end else begin
      meta_reg <= async_in;
      sync_reg <= meta_reg;
    end
  end

  // edge detection looks only at the settled copy
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      last_reg <= 1'b0;
      rise_pulse <= 1'b0;
    end else begin
      last_reg <= sync_reg;
      rise_pulse <= sync_reg & ~last_reg;
    end
  end

endmodule // gmf_edge_sync

`default_nettype wire

// file: logic/gmf_pad_ctl.sv
// module: one pad's direction and level from local and global settings
`default_nettype none

module gmf_pad_ctl (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire gmf_pkg::gmf_pin_cfg_s glob_cfg,
  input wire gmf_pkg::gmf_pin_cfg_s local_cfg,
  input wire logic remote_en,
  input wire logic remote_level,
  input wire logic func_level,
  output logic pad_out,
  output logic pad_oe_n
);

  gmf_pkg::gmf_pad_mode_e local_mode;
  gmf_pkg::gmf_pad_mode_e glob_mode;
  logic level_next;
  logic oe_n_next;

  assign local_mode = gmf_pkg::gmf_pad_mode_e'({local_cfg.direction,
    local_cfg.function_enable});
  assign glob_mode = gmf_pkg::gmf_pad_mode_e'({glob_cfg.direction,
    glob_cfg.function_enable});

  ////////////////////////////////////////////////////////////////////////////
  // local setting wins; global force only applies to a pad left at 00
  always_comb begin
    level_next = func_level;
    oe_n_next = 1'b0;
    if (local_mode != gmf_pkg::GMF_PAD_FUNC) begin
      unique case (local_mode)
        gmf_pkg::GMF_PAD_GPIO_OUT: begin
          // remote control takes the level over from the local bit
          level_next = remote_en ? remote_level : local_cfg.drive_level;
        end
        gmf_pkg::GMF_PAD_TRI,
        gmf_pkg::GMF_PAD_GPIO_IN: begin
          oe_n_next = 1'b1;
        end
        gmf_pkg::GMF_PAD_FUNC: begin
          oe_n_next = 1'b0;
        end
      endcase
    end else begin
      unique case (glob_mode)
        gmf_pkg::GMF_PAD_GPIO_OUT: begin
          level_next = glob_cfg.drive_level;
        end
        gmf_pkg::GMF_PAD_TRI,
        gmf_pkg::GMF_PAD_GPIO_IN: begin
          oe_n_next = 1'b1;
        end
        gmf_pkg::GMF_PAD_FUNC: begin
          oe_n_next = 1'b0;
        end
      endcase
    end
  end

  // registered pad drive; pad released while in reset
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      pad_out <= 1'b0;
      pad_oe_n <= 1'b1;
    end else begin
      pad_out <= level_next;
      pad_oe_n <= oe_n_next;
    end
  end

endmodule // gmf_pad_ctl

`default_nettype wire

// file: logic/gmf_regs_top.sv
// module: mailbox, pad configuration and pixel clock tally registers
//
// Notes on behaviour
// - mailbox is free 8-bit storage, resets to one
// - global level drives pins left in functional mode when forced out
// - global {dir,en}: functional, forced out, tri-state, in
// - per-pin settings override the global force
// - pin nine level only in GPIO output, where remote control can take it over
// - pin nine {dir,en}: functional, GPIO out, tri-state, GPIO in
// - tally write starts a pixel edge measurement
// - window equals written value times oscillator period
// - tally read returns edges of the latest window
// - edge count freezes at all ones
`default_nettype none

module gmf_regs_top #(
  parameter int unsigned OTHER_PINS = 4,
  parameter int unsigned WIN_W = 16
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire gmf_pkg::gmf_reg_req_s reg_req,
  output logic [7:0] reg_rdata,
  output logic reg_rdata_valid,
  input wire logic pixel_clk_in,
  input wire logic pin_nine_func_level,
  input wire logic pin_nine_remote_en,
  input wire logic pin_nine_remote_level,
  output logic pin_nine_pad_out,
  output logic pin_nine_pad_oe_n,
  input wire gmf_pkg::gmf_pin_cfg_s [OTHER_PINS-1:0] other_cfg,
  input wire logic [OTHER_PINS-1:0] other_func_level,
  input wire logic [OTHER_PINS-1:0] other_remote_en,
  input wire logic [OTHER_PINS-1:0] other_remote_level,
  output logic [OTHER_PINS-1:0] other_pad_out,
  output logic [OTHER_PINS-1:0] other_pad_oe_n
);

  logic [7:0] link_message_scratch_reg;
  logic [7:0] pin_nine_and_global_pad_config_reg;
  logic [7:0] pixel_clock_edge_tally_reg;
  logic [WIN_W-1:0] win_left_reg;
  logic [WIN_W-1:0] win_len_reg;
  logic [WIN_W-1:0] win_seen_reg;
  gmf_pkg::gmf_tally_state_e tally_state_reg;
  gmf_pkg::gmf_pin_cfg_s glob_cfg;
  gmf_pkg::gmf_pin_cfg_s pin_nine_cfg;
  logic wr_mailbox;
  logic wr_config;
  logic wr_tally;
  logic pixel_rise;
  logic win_last;
  logic [WIN_W-1:0] win_target;

  ////////////////////////////////////////////////////////////////////////////
  // address decode of the control port
  assign wr_mailbox = reg_req.wr_en &&
    (reg_req.addr == gmf_pkg::MAILBOX_OFFSET);
  assign wr_config = reg_req.wr_en &&
    (reg_req.addr == gmf_pkg::CONFIG_OFFSET);
  assign wr_tally = reg_req.wr_en &&
    (reg_req.addr == gmf_pkg::TALLY_OFFSET);

  // mailbox has no effect on hardware; both link ends just share it
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      link_message_scratch_reg <= gmf_pkg::MAILBOX_RESET;
    end else if (wr_mailbox) begin
      link_message_scratch_reg <= reg_req.wdata;
    end
  end

  // reserved bits 6 and 2 are plain storage, read back as written
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      pin_nine_and_global_pad_config_reg <= gmf_pkg::CONFIG_RESET;
    end else if (wr_config) begin
      pin_nine_and_global_pad_config_reg <= reg_req.wdata;
    end
  end

  // read port: one cycle latency, unmapped offsets read as zero
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= gmf_pkg::READ_IDLE_VALUE;
      reg_rdata_valid <= 1'b0;
    end else begin
      reg_rdata_valid <= reg_req.rd_en;
      if (reg_req.rd_en) begin
        unique case (reg_req.addr)
          gmf_pkg::MAILBOX_OFFSET: reg_rdata <= link_message_scratch_reg;
          gmf_pkg::CONFIG_OFFSET: begin
            reg_rdata <= pin_nine_and_global_pad_config_reg;
          end
          // the count, never the interval that was written
          gmf_pkg::TALLY_OFFSET: begin
            reg_rdata <= pixel_clock_edge_tally_reg;
          end
          default: reg_rdata <= gmf_pkg::READ_IDLE_VALUE;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pad configuration fields
  assign glob_cfg.drive_level =
    pin_nine_and_global_pad_config_reg[gmf_pkg::GLOB_LEVEL_BIT];
  assign glob_cfg.direction =
    pin_nine_and_global_pad_config_reg[gmf_pkg::GLOB_FORCE_DIR_BIT];
  assign glob_cfg.function_enable =
    pin_nine_and_global_pad_config_reg[gmf_pkg::GLOB_FORCE_EN_BIT];
  assign pin_nine_cfg.drive_level =
    pin_nine_and_global_pad_config_reg[gmf_pkg::PIN_NINE_LEVEL_BIT];
  assign pin_nine_cfg.direction =
    pin_nine_and_global_pad_config_reg[gmf_pkg::PIN_NINE_DIR_BIT];
  assign pin_nine_cfg.function_enable =
    pin_nine_and_global_pad_config_reg[gmf_pkg::PIN_NINE_EN_BIT];

  // pin nine uses the local bits held here
  gmf_pad_ctl u_pin_nine (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .glob_cfg(glob_cfg),
    .local_cfg(pin_nine_cfg),
    .remote_en(pin_nine_remote_en),
    .remote_level(pin_nine_remote_level),
    .func_level(pin_nine_func_level),
    .pad_out(pin_nine_pad_out),
    .pad_oe_n(pin_nine_pad_oe_n)
  );

  // other pins bring their local bits from their own registers
  for (genvar gi = 0; gi < OTHER_PINS; gi++) begin : g_other
    gmf_pad_ctl u_pad (
      .ref_clk(ref_clk),
      .arst_n(arst_n),
      .glob_cfg(glob_cfg),
      .local_cfg(other_cfg[gi]),
      .remote_en(other_remote_en[gi]),
      .remote_level(other_remote_level[gi]),
      .func_level(other_func_level[gi]),
      .pad_out(other_pad_out[gi]),
      .pad_oe_n(other_pad_oe_n[gi])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // pixel clock enters as a plain input; sampling at the reference rate
  // makes the tally a rough figure that aliases above half that rate
  gmf_edge_sync u_pixel_sync (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .async_in(pixel_clk_in),
    .rise_pulse(pixel_rise)
  );

  assign win_target =
    WIN_W'(reg_req.wdata) * WIN_W'(gmf_pkg::OSC_CYCLES);
  assign win_last = (win_left_reg == WIN_W'(1));

  // window sequencer; a new write restarts a window in progress
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      tally_state_reg <= gmf_pkg::GMF_TALLY_IDLE;
      win_left_reg <= '0;
    end else if (wr_tally) begin
      tally_state_reg <= (win_target != '0) ? gmf_pkg::GMF_TALLY_COUNT :
        gmf_pkg::GMF_TALLY_IDLE;
      win_left_reg <= win_target;
    end else if (tally_state_reg == gmf_pkg::GMF_TALLY_COUNT) begin
      win_left_reg <= win_left_reg - WIN_W'(1);
      if (win_last) begin
        tally_state_reg <= gmf_pkg::GMF_TALLY_IDLE;
      end
    end
  end

  // edge tally; cleared at start, frozen once full or window over
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      pixel_clock_edge_tally_reg <= gmf_pkg::TALLY_RESET;
    end else if (wr_tally) begin
      pixel_clock_edge_tally_reg <= gmf_pkg::TALLY_RESET;
    end else if ((tally_state_reg == gmf_pkg::GMF_TALLY_COUNT) &&
        pixel_rise &&
        (pixel_clock_edge_tally_reg != gmf_pkg::TALLY_MAX)) begin
      pixel_clock_edge_tally_reg <= pixel_clock_edge_tally_reg + 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // helper state watched only by the checks below
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      win_len_reg <= '0;
      win_seen_reg <= '0;
    end else if (wr_tally) begin
      win_len_reg <= win_target;
      win_seen_reg <= '0;
    end else if (tally_state_reg == gmf_pkg::GMF_TALLY_COUNT) begin
      win_seen_reg <= win_seen_reg + WIN_W'(1);
    end
  end

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!arst_n);

  chk_mailbox_keeps: assert property (
    wr_mailbox |=> (link_message_scratch_reg == $past(reg_req.wdata)))
    else $error("mailbox lost its written value");

  chk_mailbox_holds: assert property (
    !wr_mailbox |=> $stable(link_message_scratch_reg))
    else $error("mailbox changed without a write");

  chk_global_force_out: assert property (
    (pin_nine_cfg.direction == 1'b0) && (pin_nine_cfg.function_enable == 1'b0)
      && (glob_cfg.direction == 1'b0) && glob_cfg.function_enable
    |=> !pin_nine_pad_oe_n
      && (pin_nine_pad_out == $past(glob_cfg.drive_level)))
    else $error("global forced level not on pad");

  chk_global_tristate: assert property (
    !pin_nine_cfg.direction && !pin_nine_cfg.function_enable
      && glob_cfg.direction
    |=> pin_nine_pad_oe_n)
    else $error("global tri-state or input still drives");

  chk_global_functional: assert property (
    !pin_nine_cfg.direction && !pin_nine_cfg.function_enable
      && !glob_cfg.direction && !glob_cfg.function_enable
    |=> !pin_nine_pad_oe_n && (pin_nine_pad_out == $past(pin_nine_func_level)))
    else $error("functional output not passed to pad");

  chk_local_beats_global: assert property (
    pin_nine_cfg.direction && pin_nine_cfg.function_enable
      && !glob_cfg.direction && glob_cfg.function_enable
    |=> pin_nine_pad_oe_n)
    else $error("global force overrode local input");

  chk_local_level_out: assert property (
    !pin_nine_cfg.direction && pin_nine_cfg.function_enable
      && !pin_nine_remote_en
    |=> !pin_nine_pad_oe_n
      && (pin_nine_pad_out == $past(pin_nine_cfg.drive_level)))
    else $error("local level not driven in gpio output");

  chk_remote_level: assert property (
    !pin_nine_cfg.direction && pin_nine_cfg.function_enable
      && pin_nine_remote_en
    |=> !pin_nine_pad_oe_n
      && (pin_nine_pad_out == $past(pin_nine_remote_level)))
    else $error("remote level not driven under remote control");

  chk_local_tristate: assert property (
    pin_nine_cfg.direction && !pin_nine_cfg.function_enable
    |=> pin_nine_pad_oe_n)
    else $error("local tri-state still drives");

  chk_local_gpio_in: assert property (
    pin_nine_cfg.direction && pin_nine_cfg.function_enable
    |=> pin_nine_pad_oe_n)
    else $error("local gpio input still drives");

  chk_local_over_input: assert property (
    !pin_nine_cfg.direction && pin_nine_cfg.function_enable
      && glob_cfg.direction && glob_cfg.function_enable
    |=> !pin_nine_pad_oe_n)
    else $error("global input force overrode local output");

  chk_tally_start: assert property (
    wr_tally && (reg_req.wdata != 8'h00)
    |=> (tally_state_reg == gmf_pkg::GMF_TALLY_COUNT)
      && (pixel_clock_edge_tally_reg == gmf_pkg::TALLY_RESET))
    else $error("tally write did not start a window");

  chk_tally_zero_write: assert property (
    wr_tally && (reg_req.wdata == 8'h00)
    |=> (tally_state_reg == gmf_pkg::GMF_TALLY_IDLE)
      && (pixel_clock_edge_tally_reg == gmf_pkg::TALLY_RESET))
    else $error("zero interval left a window open");

  chk_window_length: assert property (
    (tally_state_reg == gmf_pkg::GMF_TALLY_IDLE)
      && ($past(tally_state_reg) == gmf_pkg::GMF_TALLY_COUNT)
      && !$past(wr_tally)
    |-> (win_seen_reg == win_len_reg))
    else $error("window length differs from written value");

  chk_tally_read: assert property (
    reg_req.rd_en && (reg_req.addr == gmf_pkg::TALLY_OFFSET)
    |=> reg_rdata_valid && (reg_rdata == $past(pixel_clock_edge_tally_reg)))
    else $error("tally read returned wrong value");

  chk_tally_freeze: assert property (
    (pixel_clock_edge_tally_reg == gmf_pkg::TALLY_MAX) && !wr_tally
    |=> (pixel_clock_edge_tally_reg == gmf_pkg::TALLY_MAX))
    else $error("tally wrapped past full");

  chk_tally_step: assert property (
    (tally_state_reg == gmf_pkg::GMF_TALLY_COUNT) && pixel_rise && !wr_tally
      && (pixel_clock_edge_tally_reg != gmf_pkg::TALLY_MAX)
    |=> (pixel_clock_edge_tally_reg ==
      $past(pixel_clock_edge_tally_reg) + 8'h01))
    else $error("pixel edge not counted in window");

  chk_tally_stable: assert property (
    (tally_state_reg == gmf_pkg::GMF_TALLY_IDLE) && !wr_tally
    |=> $stable(pixel_clock_edge_tally_reg))
    else $error("tally moved outside a window");

endmodule // gmf_regs_top

`default_nettype wire

// file: testbench/gmf_regs_top_bench.sv
// testbench: register, pad and pixel tally checks for gmf_regs_top
`default_nettype none

module gmf_regs_top_bench;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int unsigned NP = 4;
  localparam int unsigned LIMIT = 5000;

  logic ref_clk;
  logic arst_n;
  gmf_pkg::gmf_reg_req_s reg_req;
  logic [7:0] reg_rdata;
  logic reg_rdata_valid;
  logic pixel_clk_in;
  logic pin_nine_func_level;
  logic pin_nine_remote_en;
  logic pin_nine_remote_level;
  logic pin_nine_pad_out;
  logic pin_nine_pad_oe_n;
  gmf_pkg::gmf_pin_cfg_s [NP-1:0] other_cfg;
  logic [NP-1:0] other_func_level;
  logic [NP-1:0] other_remote_en;
  logic [NP-1:0] other_remote_level;
  logic [NP-1:0] other_pad_out;
  logic [NP-1:0] other_pad_oe_n;
  int n_errors;
  int checks;
  int cycles;
  int pix_half;
  int pix_cnt;

  gmf_regs_top #(.OTHER_PINS(NP), .WIN_W(16)) dut (
    .ref_clk(ref_clk), .arst_n(arst_n), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .reg_rdata_valid(reg_rdata_valid),
    .pixel_clk_in(pixel_clk_in),
    .pin_nine_func_level(pin_nine_func_level),
    .pin_nine_remote_en(pin_nine_remote_en),
    .pin_nine_remote_level(pin_nine_remote_level),
    .pin_nine_pad_out(pin_nine_pad_out),
    .pin_nine_pad_oe_n(pin_nine_pad_oe_n), .other_cfg(other_cfg),
    .other_func_level(other_func_level),
    .other_remote_en(other_remote_en),
    .other_remote_level(other_remote_level),
    .other_pad_out(other_pad_out), .other_pad_oe_n(other_pad_oe_n)
  );

  ////////////////////////////////////////////////////////////////////////////
  // 25 MHz reference clock
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  // pixel clock on the reference grid, so edge counts are predictable
  always @(posedge ref_clk) begin
    if (pix_half == 0) begin
      pix_cnt <= 0;
    end else if (pix_cnt + 1 >= pix_half) begin
      pix_cnt <= 0;
      pixel_clk_in <= ~pixel_clk_in;
    end else begin
      pix_cnt <= pix_cnt + 1;
    end
  end

  // hang guard: counts as a mismatch and closes the run
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      n_errors++;
      $display("unexpected %0t ns: run did not finish in time", $time);
      wrap_up();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up();
    $display("comparisons %0d, mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %0t ns: got %h want %h", $time, seen, exp);
    end
  endtask

  // one write strobe; takes effect at the edge that sees it
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_req <= '{wr_en: 1'b1, rd_en: 1'b0, addr: a, wdata: d};
    @(posedge ref_clk);
    reg_req <= '0;
  endtask

  // one read strobe; data and valid come one cycle later, valid for one
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    reg_req <= '{wr_en: 1'b0, rd_en: 1'b1, addr: a, wdata: 8'h00};
    @(posedge ref_clk);
    reg_req <= '0;
    #1;
    check({7'b0, reg_rdata_valid}, 8'h01);
    d = reg_rdata;
    @(posedge ref_clk);
    #1;
    check({7'b0, reg_rdata_valid}, 8'h00);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] got;
    rd(a, got);
    check(got, exp);
  endtask

  // pat = {global level, local level, functional level}, set apart
  task automatic pad_case(input logic [1:0] g, input logic [1:0] l,
                          input logic [2:0] pat, input logic rem);
    logic oe_n;
    logic out;
    @(posedge ref_clk);
    pin_nine_func_level <= pat[0];
    pin_nine_remote_en <= rem;
    pin_nine_remote_level <= ~pat[1];
    other_func_level <= {NP{pat[0]}};
    other_remote_en <= {NP{rem}};
    other_remote_level <= {NP{~pat[1]}};
    for (int i = 0; i < NP; i++) begin
      other_cfg[i] <= '{drive_level: pat[1], direction: l[1],
                        function_enable: l[0]};
    end
    wr(gmf_pkg::CONFIG_OFFSET, {pat[2], 1'b0, g, pat[1], 1'b0, l});
    out = 1'b0;
    oe_n = 1'b1;
    if (l == 2'b01) begin
      oe_n = 1'b0;
      out = rem ? ~pat[1] : pat[1];
    end else if (l == 2'b00 && g == 2'b00) begin
      oe_n = 1'b0;
      out = pat[0];
    end else if (l == 2'b00 && g == 2'b01) begin
      oe_n = 1'b0;
      out = pat[2];
    end
    repeat (2) @(posedge ref_clk);
    #1;
    check({7'b0, pin_nine_pad_oe_n}, {7'b0, oe_n});
    check({4'h0, other_pad_oe_n}, {4'h0, {NP{oe_n}}});
    if (!oe_n) begin
      check({7'b0, pin_nine_pad_out}, {7'b0, out});
      check({4'h0, other_pad_out}, {4'h0, {NP{out}}});
    end
  endtask

  // one window of n reference periods, pixel period 2*half periods
  task automatic tally_run(input logic [7:0] n, input int half);
    logic [7:0] got;
    logic [7:0] again;
    logic ok;
    int exp;
    exp = int'(n) / (2 * half);
    pix_half = half;
    wr(gmf_pkg::TALLY_OFFSET, n);
    repeat (int'(n) + 8) @(posedge ref_clk);
    rd(gmf_pkg::TALLY_OFFSET, got);
    if (n == 8'h00) begin
      check(got, 8'h00);
    end else begin
      // the count is a rough figure: one edge either way is accepted
      ok = (int'(got) + 1 >= exp) && (int'(got) <= exp + 1);
      check({7'b0, ok}, 8'h01);
    end
    // pixel clock keeps running: the result must not move
    repeat (20) @(posedge ref_clk);
    rd(gmf_pkg::TALLY_OFFSET, again);
    check(again, got);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    arst_n = 1'b0;
    reg_req = '0;
    pixel_clk_in = 1'b0;
    pin_nine_func_level = 1'b0;
    pin_nine_remote_en = 1'b0;
    pin_nine_remote_level = 1'b0;
    other_cfg = '0;
    other_func_level = '0;
    other_remote_en = '0;
    other_remote_level = '0;
    n_errors = 0;
    checks = 0;
    cycles = 0;
    pix_half = 0;
    pix_cnt = 0;
    repeat (10) @(posedge ref_clk);
    arst_n <= 1'b1;
    rd_chk(gmf_pkg::MAILBOX_OFFSET, gmf_pkg::MAILBOX_RESET);
    rd_chk(gmf_pkg::CONFIG_OFFSET, gmf_pkg::CONFIG_RESET);
    rd_chk(gmf_pkg::TALLY_OFFSET, gmf_pkg::TALLY_RESET);
    wr(gmf_pkg::MAILBOX_OFFSET, 8'ha5);
    rd_chk(gmf_pkg::MAILBOX_OFFSET, 8'ha5);
    wr(gmf_pkg::MAILBOX_OFFSET, 8'h5a);
    rd_chk(gmf_pkg::MAILBOX_OFFSET, 8'h5a);
    // unmapped neighbours: writes lost, reads give the idle value
    wr(8'h18, 8'h33);
    rd_chk(8'h18, gmf_pkg::READ_IDLE_VALUE);
    rd_chk(8'h1c, gmf_pkg::READ_IDLE_VALUE);
    rd_chk(gmf_pkg::MAILBOX_OFFSET, 8'h5a);
    wr(gmf_pkg::CONFIG_OFFSET, 8'hff);
    rd_chk(gmf_pkg::CONFIG_OFFSET, 8'hff);
    // every global and local mode pair, levels told apart
    for (int g = 0; g < 4; g++) begin
      for (int l = 0; l < 4; l++) begin
        for (int p = 1; p < 7; p++) begin
          pad_case(2'(g), 2'(l), 3'(p), 1'b0);
        end
      end
    end
    pad_case(2'b11, 2'b01, 3'b010, 1'b1);
    pad_case(2'b01, 2'b01, 3'b101, 1'b1);
    tally_run(8'd40, 2);
    tally_run(8'd80, 2);
    // fastest sampled pixel clock: about half the window, short of full
    tally_run(8'd255, 1);
    tally_run(8'd0, 2);
    // a second write in mid-window restarts the count from zero
    wr(gmf_pkg::TALLY_OFFSET, 8'd200);
    repeat (30) @(posedge ref_clk);
    tally_run(8'd40, 2);
    // reset in mid-run brings every register back
    wr(gmf_pkg::MAILBOX_OFFSET, 8'h77);
    @(posedge ref_clk);
    arst_n <= 1'b0;
    repeat (10) @(posedge ref_clk);
    arst_n <= 1'b1;
    rd_chk(gmf_pkg::MAILBOX_OFFSET, gmf_pkg::MAILBOX_RESET);
    rd_chk(gmf_pkg::CONFIG_OFFSET, gmf_pkg::CONFIG_RESET);
    rd_chk(gmf_pkg::TALLY_OFFSET, gmf_pkg::TALLY_RESET);
    wrap_up();
  end

endmodule // gmf_regs_top_bench

`default_nettype wire
